// >>> hdl/pirf_top.sv
// peripheral interrupt request flag registers with APB access and request output
//
// Contract
// - flags set by events, ignoring any enable
// - flag one means pending, zero none
// - first register bit 4 is serial transmit
// - first register bit 3 is sync port 1
// - first register bit 2 is capture/compare 1
// - first register bit 1 is timer two match
// - second register bit 7 is oscillator fail
// - second register bit 6 is comparator two
// - second register bit 5 is comparator one
// - second register bit 4 is eeprom done
// - second register bit 3 is port 1 collision
// - bit 0 capcomp2 large only; 2:1 zero
// - second register read/write, reset to zero
// - third register exists on larger member only
// - request needs peripheral gate bit set
module pirf_top
    import pirf_pkg::*;
#(
    parameter bit LARGE_MEMBER = 1'b1
)
(
    input wire logic mclk, // core clock, 25 MHz
    input wire logic rst, // async reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic serialTxEvt, // transmit buffer free
    input wire logic serialTxClear, // transmit buffer loaded
    input wire logic syncPort1Evt, // sync port 1 event
    input wire logic capcomp1Evt, // capture/compare 1 event
    input wire logic timerTwoMatchEvt, // timer two equals its period
    input wire logic oscFailEvt, // clock oscillator failed
    input wire logic comparatorTwoEvt, // comparator two edge
    input wire logic comparatorOneEvt, // comparator one edge
    input wire logic eepromWriteDoneEvt, // eeprom write finished
    input wire logic syncPort1CollisionEvt, // sync port 1 bus collision
    input wire logic capcomp2Evt, // capture/compare 2 event
    input wire logic capcomp4Evt, // capture/compare 4 event
    input wire logic capcomp3Evt, // capture/compare 3 event
    input wire logic timerSixMatchEvt, // timer six equals its period
    input wire logic timerFourMatchEvt, // timer four equals its period
    output logic periphIrq // gated peripheral request to the core
);
    logic [7:0] implOne;
    logic [7:0] implTwo;
    logic [7:0] implThree;
    logic [7:0] evtOne;
    logic [7:0] evtTwo;
    logic [7:0] evtThree;
    logic [7:0] flagsOne;
    logic [7:0] flagsTwo;
    logic [7:0] flagsThree;
    logic [7:0] enOne_reg;
    logic [7:0] enTwo_reg;
    logic [7:0] enThree_reg;
    logic [7:0] coreCtrl_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic periphIrq_reg;
    logic periphIrq_next;
    logic addrHit;
    logic wrAccess;
    logic wrOne;
    logic wrTwo;
    logic wrThree;
    logic [7:0] clrOne;

    assign implOne = PIRF_ONE_IMPL;
    assign implTwo = PIRF_TWO_IMPL_BASE | (LARGE_MEMBER ? PIRF_TWO_LARGE_ONLY : 8'h00);
    assign implThree = LARGE_MEMBER ? PIRF_THREE_IMPL : 8'h00;

    // event vectors laid out at the documented bit positions
    always_comb
    begin
        evtOne = 8'h00;
        evtOne[PIRF_ONE_SERIAL_TX] = serialTxEvt;
        evtOne[PIRF_ONE_SYNC_PORT1] = syncPort1Evt;
        evtOne[PIRF_ONE_CAPCOMP1] = capcomp1Evt;
        evtOne[PIRF_ONE_TIMER_TWO] = timerTwoMatchEvt;
    end

    always_comb
    begin
        evtTwo = 8'h00;
        evtTwo[PIRF_TWO_OSC_FAIL] = oscFailEvt;
        evtTwo[PIRF_TWO_COMPARATOR_TWO] = comparatorTwoEvt;
        evtTwo[PIRF_TWO_COMPARATOR_ONE] = comparatorOneEvt;
        evtTwo[PIRF_TWO_EEPROM_DONE] = eepromWriteDoneEvt;
        evtTwo[PIRF_TWO_SYNC_COLLISION] = syncPort1CollisionEvt;
        evtTwo[PIRF_TWO_CAPCOMP2] = capcomp2Evt;
    end

    always_comb
    begin
        evtThree = 8'h00;
        evtThree[PIRF_THREE_CAPCOMP4] = capcomp4Evt;
        evtThree[PIRF_THREE_CAPCOMP3] = capcomp3Evt;
        evtThree[PIRF_THREE_TIMER_SIX] = timerSixMatchEvt;
        evtThree[PIRF_THREE_TIMER_FOUR] = timerFourMatchEvt;
    end

    // apb decode; zero wait states, so every access phase completes
    assign pready = 1'b1;
    assign wrAccess = psel && penable && pwrite;

    always_comb
    begin
        addrHit = 1'b1;
        unique case (paddr)
            PIRF_OFF_FLAGS_ONE, PIRF_OFF_FLAGS_TWO, PIRF_OFF_EN_ONE, PIRF_OFF_EN_TWO, PIRF_OFF_CORE_CTRL:
                addrHit = 1'b1;
            PIRF_OFF_FLAGS_THREE, PIRF_OFF_EN_THREE:
                addrHit = LARGE_MEMBER;
            default:
                addrHit = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addrHit;
    assign wrOne = wrAccess && (paddr == PIRF_OFF_FLAGS_ONE);
    assign wrTwo = wrAccess && (paddr == PIRF_OFF_FLAGS_TWO);
    assign wrThree = wrAccess && (paddr == PIRF_OFF_FLAGS_THREE) && LARGE_MEMBER;

    // transmit flag is read-only: only the transmitter clears it
    always_comb
    begin
        clrOne = 8'h00;
        clrOne[PIRF_ONE_SERIAL_TX] = serialTxClear;
    end

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_flag
            pirf_flag_bit u_one (
                .mclk(mclk),
                .rst(rst),
                .present(implOne[i]),
                .setEvt(evtOne[i]),
                .wrEn((wrOne && PIRF_ONE_SW_WRITABLE[i]) || clrOne[i]),
                .wrVal(pwdata[i] && !clrOne[i]),
                .flag(flagsOne[i])
            );
            pirf_flag_bit u_two (
                .mclk(mclk),
                .rst(rst),
                .present(implTwo[i]),
                .setEvt(evtTwo[i]),
                .wrEn(wrTwo),
                .wrVal(pwdata[i]),
                .flag(flagsTwo[i])
            );
            pirf_flag_bit u_three (
                .mclk(mclk),
                .rst(rst),
                .present(implThree[i]),
                .setEvt(evtThree[i]),
                .wrEn(wrThree),
                .wrVal(pwdata[i]),
                .flag(flagsThree[i])
            );
        end
    endgenerate

    // enable registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            enOne_reg <= PIRF_REG_RESET;
            enTwo_reg <= PIRF_REG_RESET;
            enThree_reg <= PIRF_REG_RESET;
        end
        else if (wrAccess)
        begin
            if (paddr == PIRF_OFF_EN_ONE)
                enOne_reg <= pwdata[7:0] & implOne;
            if (paddr == PIRF_OFF_EN_TWO)
                enTwo_reg <= pwdata[7:0] & implTwo;
            if (paddr == PIRF_OFF_EN_THREE)
                enThree_reg <= pwdata[7:0] & implThree;
        end
    end

    // core control: global enable and peripheral gate
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            coreCtrl_reg <= PIRF_REG_RESET;
        else if (wrAccess && (paddr == PIRF_OFF_CORE_CTRL))
            coreCtrl_reg <= pwdata[7:0] & PIRF_CORE_IMPL;
    end

    // read data sampled in the setup cycle, so prdata comes from a flop
    always_comb
    begin
        prdata_next = 32'h0000_0000;
        unique case (paddr)
            PIRF_OFF_FLAGS_ONE:
                prdata_next[7:0] = flagsOne & implOne;
            PIRF_OFF_FLAGS_TWO:
                prdata_next[7:0] = flagsTwo & implTwo;
            PIRF_OFF_FLAGS_THREE:
                prdata_next[7:0] = flagsThree & implThree;
            PIRF_OFF_EN_ONE:
                prdata_next[7:0] = enOne_reg;
            PIRF_OFF_EN_TWO:
                prdata_next[7:0] = enTwo_reg;
            PIRF_OFF_EN_THREE:
                prdata_next[7:0] = enThree_reg;
            PIRF_OFF_CORE_CTRL:
                prdata_next[7:0] = coreCtrl_reg;
            default:
                prdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            prdata_reg <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata_reg <= prdata_next;
    end

    assign prdata = prdata_reg;

    // request: OR of enabled flags, then gate and global enable
    assign periphIrq_next = (|((flagsOne & enOne_reg) | (flagsTwo & enTwo_reg) | (flagsThree & enThree_reg)))
        && coreCtrl_reg[PIRF_CORE_PERIPH_GATE]
        && coreCtrl_reg[PIRF_CORE_GLOBAL_EN];

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            periphIrq_reg <= 1'b0;
        else
            periphIrq_reg <= periphIrq_next;
    end

    assign periphIrq = periphIrq_reg;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_set_over_clear: assert property (
        (oscFailEvt && wrTwo && !pwdata[PIRF_TWO_OSC_FAIL]) |=> flagsTwo[PIRF_TWO_OSC_FAIL])
        else $error("hardware set lost against software clear");

    a_write_zero_clears: assert property (
        (wrTwo && !pwdata[PIRF_TWO_COMPARATOR_ONE] && !comparatorOneEvt) |=> !flagsTwo[PIRF_TWO_COMPARATOR_ONE])
        else $error("write of zero did not clear flag");

    a_set_ignores_enable: assert property (
        (timerTwoMatchEvt && !enOne_reg[PIRF_ONE_TIMER_TWO] && !coreCtrl_reg[PIRF_CORE_GLOBAL_EN])
        |=> flagsOne[PIRF_ONE_TIMER_TWO])
        else $error("disabled event did not set its flag");

    a_tx_bit_place: assert property (
        (serialTxEvt && !$past(serialTxEvt)) |=> flagsOne[PIRF_ONE_SERIAL_TX] ##0 !flagsOne[0])
        else $error("serial transmit flag not at bit 4");

    a_eeprom_sticky: assert property (
        (eepromWriteDoneEvt ##1 !wrTwo [*3]) |-> flagsTwo[PIRF_TWO_EEPROM_DONE])
        else $error("eeprom done flag did not stay set");

    a_unimpl_zero: assert property (
        flagsTwo[2:1] == 2'b00 && flagsOne[7:5] == 3'b000)
        else $error("unimplemented flag bit is set");

    a_reset_clears: assert property (
        $past(rst) |-> (flagsTwo == 8'h00 && periphIrq == 1'b0))
        else $error("flags not clear after reset");

    a_read_pending: assert property (
        (psel && !penable && !pwrite && paddr == PIRF_OFF_FLAGS_TWO)
        |=> (prdata[7:0] == $past(flagsTwo & implTwo)) && prdata[31:8] == 24'h000000)
        else $error("read of second flags does not show pending state");

    a_small_member: assert property (
        !LARGE_MEMBER |-> (flagsThree == 8'h00 && flagsTwo[PIRF_TWO_CAPCOMP2] == 1'b0))
        else $error("large member only bit present on small member");

    a_irq_gate: assert property (
        (!coreCtrl_reg[PIRF_CORE_PERIPH_GATE]) |=> !periphIrq)
        else $error("request passed a closed peripheral gate");

    a_irq_source: assert property (
        periphIrq == $past((|(flagsTwo & enTwo_reg) || |(flagsOne & enOne_reg) || |(flagsThree & enThree_reg))
            && coreCtrl_reg[PIRF_CORE_GLOBAL_EN] && coreCtrl_reg[PIRF_CORE_PERIPH_GATE]))
        else $error("request does not follow enabled flags");

    a_unmapped_err: assert property (
        (psel && penable && !addrHit) |-> pslverr && pready)
        else $error("unmapped access not flagged");

    c_set_and_clear: cover property (oscFailEvt && wrTwo);
    c_irq_raised: cover property ($rose(periphIrq));
    c_flag_read: cover property (psel && penable && !pwrite && paddr == PIRF_OFF_FLAGS_ONE && prdata[7:0] != 8'h00);
    c_collision: cover property (syncPort1CollisionEvt ##1 flagsTwo[PIRF_TWO_SYNC_COLLISION]);
endmodule

// >>> hdl/pirf_pkg.sv
// register map, field positions and reset values of the peripheral request flags
package pirf_pkg;
    localparam logic [7:0] PIRF_OFF_FLAGS_ONE = 8'h00;
    localparam logic [7:0] PIRF_OFF_FLAGS_TWO = 8'h04;
    localparam logic [7:0] PIRF_OFF_FLAGS_THREE = 8'h08;
    localparam logic [7:0] PIRF_OFF_EN_ONE = 8'h0c;
    localparam logic [7:0] PIRF_OFF_EN_TWO = 8'h10;
    localparam logic [7:0] PIRF_OFF_EN_THREE = 8'h14;
    localparam logic [7:0] PIRF_OFF_CORE_CTRL = 8'h18;

    localparam int PIRF_ONE_SERIAL_TX = 4;
    localparam int PIRF_ONE_SYNC_PORT1 = 3;
    localparam int PIRF_ONE_CAPCOMP1 = 2;
    localparam int PIRF_ONE_TIMER_TWO = 1;

    localparam int PIRF_TWO_OSC_FAIL = 7;
    localparam int PIRF_TWO_COMPARATOR_TWO = 6;
    localparam int PIRF_TWO_COMPARATOR_ONE = 5;
    localparam int PIRF_TWO_EEPROM_DONE = 4;
    localparam int PIRF_TWO_SYNC_COLLISION = 3;
    localparam int PIRF_TWO_CAPCOMP2 = 0;

    localparam int PIRF_THREE_CAPCOMP4 = 5;
    localparam int PIRF_THREE_CAPCOMP3 = 4;
    localparam int PIRF_THREE_TIMER_SIX = 3;
    localparam int PIRF_THREE_TIMER_FOUR = 1;

    localparam int PIRF_CORE_GLOBAL_EN = 7;
    localparam int PIRF_CORE_PERIPH_GATE = 6;

    localparam logic [7:0] PIRF_ONE_IMPL = 8'h1e;
    localparam logic [7:0] PIRF_ONE_SW_WRITABLE = 8'h0e;
    localparam logic [7:0] PIRF_TWO_IMPL_BASE = 8'hf8;
    localparam logic [7:0] PIRF_TWO_LARGE_ONLY = 8'h01;
    localparam logic [7:0] PIRF_THREE_IMPL = 8'h3a;
    localparam logic [7:0] PIRF_CORE_IMPL = 8'hc0;
    localparam logic [7:0] PIRF_REG_RESET = 8'h00;
endpackage

// >>> hdl/pirf_flag_bit.sv
// one request flag: hardware set, software or hardware write, set wins
module pirf_flag_bit
    import pirf_pkg::*;
(
    input wire logic mclk, // core clock
    input wire logic rst, // async reset, active high
    input wire logic present, // bit exists on this variant
    input wire logic setEvt, // peripheral event pulse
    input wire logic wrEn, // write strobe for this bit
    input wire logic wrVal, // value written
    output logic flag // stored flag
);
    logic flag_reg;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            flag_reg <= 1'b0;
        else if (!present)
            flag_reg <= 1'b0;
        else if (setEvt)
            flag_reg <= 1'b1;
        else if (wrEn)
            flag_reg <= wrVal;
    end

    assign flag = flag_reg;
endmodule

// >>> tb/pirf_top_tb.sv
// self-checking bench for the peripheral request flag registers
module pirf_top_tb
    import pirf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed { logic rd; logic err; logic [31:0] data; } pirf_note_s;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic periphIrq;
    logic [13:0] evts = 14'h0;
    logic txClear = 1'b0;
    int miscompares = 0;
    int cmpCount = 0;
    pirf_note_s notes[$];
    pirf_note_s cur;
    logic [7:0] offs [14] = '{PIRF_OFF_FLAGS_ONE, PIRF_OFF_FLAGS_ONE, PIRF_OFF_FLAGS_ONE, PIRF_OFF_FLAGS_ONE,
        PIRF_OFF_FLAGS_TWO, PIRF_OFF_FLAGS_TWO, PIRF_OFF_FLAGS_TWO, PIRF_OFF_FLAGS_TWO, PIRF_OFF_FLAGS_TWO,
        PIRF_OFF_FLAGS_TWO, PIRF_OFF_FLAGS_THREE, PIRF_OFF_FLAGS_THREE, PIRF_OFF_FLAGS_THREE, PIRF_OFF_FLAGS_THREE};
    int bitPos [14] = '{PIRF_ONE_SERIAL_TX, PIRF_ONE_SYNC_PORT1, PIRF_ONE_CAPCOMP1, PIRF_ONE_TIMER_TWO,
        PIRF_TWO_OSC_FAIL, PIRF_TWO_COMPARATOR_TWO, PIRF_TWO_COMPARATOR_ONE, PIRF_TWO_EEPROM_DONE,
        PIRF_TWO_SYNC_COLLISION, PIRF_TWO_CAPCOMP2, PIRF_THREE_CAPCOMP4, PIRF_THREE_CAPCOMP3,
        PIRF_THREE_TIMER_SIX, PIRF_THREE_TIMER_FOUR};

    always #20 mclk = ~mclk;

    pirf_top #(.LARGE_MEMBER(1'b1)) DUT (
        .mclk(mclk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .serialTxEvt(evts[0]),
        .serialTxClear(txClear),
        .syncPort1Evt(evts[1]),
        .capcomp1Evt(evts[2]),
        .timerTwoMatchEvt(evts[3]),
        .oscFailEvt(evts[4]),
        .comparatorTwoEvt(evts[5]),
        .comparatorOneEvt(evts[6]),
        .eepromWriteDoneEvt(evts[7]),
        .syncPort1CollisionEvt(evts[8]),
        .capcomp2Evt(evts[9]),
        .capcomp4Evt(evts[10]),
        .capcomp3Evt(evts[11]),
        .timerSixMatchEvt(evts[12]),
        .timerFourMatchEvt(evts[13]),
        .periphIrq(periphIrq)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one apb transfer; evm drives events during the access cycle only
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
        input logic err, input logic [13:0] evm);
        int n;
        notes.push_back('{rd: !wr, err: err, data: exp});
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        evts <= evm;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        evts <= 14'h0;
        if (pready !== 1'b1)
        begin
            miscompares++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0, 1'b0, 14'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, exp, 1'b0, 14'h0);
    endtask

    task automatic pulse(input logic [13:0] m);
        @(posedge mclk);
        evts <= m;
        @(posedge mclk);
        evts <= 14'h0;
    endtask

    task automatic irqIs(input logic exp);
        @(negedge mclk);
        check({31'h0, periphIrq}, {31'h0, exp});
    endtask

    // read data is valid during the access cycle, so it is taken at the access edge
    always @(posedge mclk)
    begin
        if (psel && penable && pready)
        begin
            if (notes.size() == 0)
                check(32'h1, 32'h0);
            else
            begin
                cur = notes.pop_front();
                if (cur.rd)
                    check(prdata, cur.data);
                check({31'h0, pslverr}, {31'h0, cur.err});
            end
        end
    end

    initial
    begin
        logic [31:0] d;
        void'($urandom(51));
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a <= 8'h18; a += 4)
            rd(a[7:0], 32'h0);
        // enables and gates all zero: flags must still set
        for (int i = 0; i < 14; i++)
        begin
            pulse(14'h1 << i);
            rd(offs[i], 32'h1 << bitPos[i]);
            if (i == 0)
            begin
                @(posedge mclk);
                txClear <= 1'b1;
                @(posedge mclk);
                txClear <= 1'b0;
            end
            else
                wr(offs[i], 32'h0);
        end
        rd(PIRF_OFF_FLAGS_ONE, 32'h0);
        rd(PIRF_OFF_FLAGS_TWO, 32'h0);
        rd(PIRF_OFF_FLAGS_THREE, 32'h0);
        wr(PIRF_OFF_FLAGS_ONE, 32'h1e);
        rd(PIRF_OFF_FLAGS_ONE, 32'h0e);
        wr(PIRF_OFF_FLAGS_ONE, 32'h0);
        wr(PIRF_OFF_FLAGS_TWO, 32'hffffffff);
        rd(PIRF_OFF_FLAGS_TWO, 32'hf9);
        repeat (4)
        begin
            d = $urandom;
            wr(PIRF_OFF_FLAGS_TWO, d);
            rd(PIRF_OFF_FLAGS_TWO, {24'h0, d[7:0] & 8'hf9});
        end
        // clear and event on the same edge: the event must survive
        pulse(14'h1 << 5);
        xfer(1'b1, PIRF_OFF_FLAGS_TWO, 32'h0, 32'h0, 1'b0, 14'h1 << 4);
        rd(PIRF_OFF_FLAGS_TWO, 32'h80);
        wr(PIRF_OFF_FLAGS_TWO, 32'h0);
        xfer(1'b1, 8'h1c, 32'hff, 32'h0, 1'b1, 14'h0);
        xfer(1'b0, 8'h1c, 32'h0, 32'h0, 1'b1, 14'h0);
        wr(PIRF_OFF_EN_TWO, 32'h80);
        wr(PIRF_OFF_CORE_CTRL, 32'hc0);
        irqIs(1'b0);
        pulse(14'h1 << 4);
        irqIs(1'b0);
        irqIs(1'b1);
        wr(PIRF_OFF_CORE_CTRL, 32'h80);
        // request is registered: the old gate still shows for one cycle
        irqIs(1'b1);
        repeat (2) irqIs(1'b0);
        wr(PIRF_OFF_CORE_CTRL, 32'h40);
        repeat (2) irqIs(1'b0);
        wr(PIRF_OFF_CORE_CTRL, 32'hc0);
        repeat (2) @(negedge mclk);
        irqIs(1'b1);
        wr(PIRF_OFF_EN_TWO, 32'h0);
        irqIs(1'b1);
        repeat (2) irqIs(1'b0);
        // reset in mid-run clears flags, enables and gates
        wr(PIRF_OFF_EN_TWO, 32'h80);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(PIRF_OFF_FLAGS_TWO, 32'h0);
        rd(PIRF_OFF_EN_TWO, 32'h0);
        rd(PIRF_OFF_CORE_CTRL, 32'h0);
        repeat (3) @(posedge mclk);
        check(32'(notes.size()), 32'h0);
        close_out();
    end
endmodule
